// file: rtl/wfm_consts.vh
// Notes on behaviour
// RULE1 - watchdog expired flag sets when not serviced
// RULE2 - expired flag reads zero before period runs
// RULE3 - expired watchdog trips fault, opens contactors
// RULE4 - freshness stale flag sets without data update
// RULE5 - stale flag reads zero while data updated
// RULE6 - cell monitor: installed cells, typically 3 s
// RULE7 - thermistor monitor: installed thermistors, typically 10 s
// RULE8 - module status monitor: installed modules, 3 s
// RULE9 - open-wire monitor refreshed per run, 120 s
// RULE10 - stack power monitor, typically 60 s
// RULE11 - link power-check monitor, typically 3 s
// RULE12 - controller and power side config monitors, 60 s
// RULE13 - RAM and ROM self-test watchdogs, 60 s
// RULE14 - service or update restarts count, clears flag
// RULE15 - periods counted in microseconds, held in registers
`ifndef WFM_CONSTS_VH
`define WFM_CONSTS_VH

`define WFM_CLK_MHZ         125
`define WFM_US_CYCLES       (`WFM_CLK_MHZ)
`define WFM_US_LAST         7'h7C
`define WFM_NUM_TIMERS      10
`define WFM_PER_W           32

// timer index: 0..7 freshness, 8..9 watchdogs
`define WFM_T_CELL          0
`define WFM_T_THERM         1
`define WFM_T_MODSTAT       2
`define WFM_T_OPENWIRE      3
`define WFM_T_POWER         4
`define WFM_T_LINKPWR       5
`define WFM_T_CTRLCFG       6
`define WFM_T_PWRCFG        7
`define WFM_T_RAMGUARD      8
`define WFM_T_ROMGUARD      9

// default periods in microseconds
`define WFM_PER_CELL_US     32'd3000000
`define WFM_PER_THERM_US    32'd10000000
`define WFM_PER_MODSTAT_US  32'd3000000
`define WFM_PER_OPENWIRE_US 32'd120000000
`define WFM_PER_POWER_US    32'd60000000
`define WFM_PER_LINKPWR_US  32'd3000000
`define WFM_PER_CFG_US      32'd60000000
`define WFM_PER_SELFTEST_US 32'd60000000

// register offsets (byte addresses)
`define WFM_A_PERIOD0       8'h00
`define WFM_A_FLAGS         8'h40
`define WFM_A_STATUS        8'h44
`define WFM_A_MASK          8'h48
`define WFM_A_CTRL          8'h4C

// control bits
`define WFM_CTRL_FAULT_CLR  0
`define WFM_CTRL_FAULT_EN   1
`define WFM_CTRL_RST        8'h02

`endif

// file: rtl/wfm_watchdog_freshness_monitor.v
`timescale 1ns/1ps
`default_nettype none
`include "wfm_consts.vh"

module wfm_timer (
  input  wire        clk_i,
  input  wire        rst_n_i,
  input  wire        us_tick_i,
  input  wire        refresh_i,
  input  wire        active_i,
  input  wire [31:0] period_i,
  output reg         flag_o
);
  reg  [31:0] count;
  wire        run_out;

  // a refresh beats a run-out in the same cycle, so a fresh sample is never flagged
  assign run_out = us_tick_i && (count + 32'h0000_0001 >= period_i);

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count <= 32'h0000_0000;
    end else if (refresh_i || !active_i) begin
      count <= 32'h0000_0000; // [RULE14]
    end else if (us_tick_i && !run_out) begin
      count <= count + 32'h0000_0001;
    end
  end

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flag_o <= 1'b0;
    end else if (refresh_i || !active_i) begin
      flag_o <= 1'b0; // [RULE2] [RULE5]
    end else if (run_out) begin
      flag_o <= 1'b1; // [RULE1] [RULE4]
    end
  end
endmodule

module wfm_watchdog_freshness_monitor (
  input  wire        clk_i,
  input  wire        rst_n_i,
  input  wire [7:0]  addr_i,
  input  wire [31:0] wdata_i,
  input  wire        wr_i,
  input  wire        rd_i,
  output reg  [31:0] rdata_o,
  input  wire        cell_update_i,
  input  wire        therm_update_i,
  input  wire        module_status_update_i,
  input  wire        open_wire_run_i,
  input  wire        stack_power_update_i,
  input  wire        link_power_check_i,
  input  wire        controller_config_check_i,
  input  wire        power_side_config_check_i,
  input  wire        ram_selftest_service_i,
  input  wire        rom_selftest_service_i,
  input  wire        cells_installed_i,
  input  wire        therms_installed_i,
  input  wire        modules_installed_i,
  output wire [7:0]  stale_o,
  output wire [1:0]  expired_o,
  output reg         fault_o,
  output wire        contactor_open_o,
  output wire        irq_o
);
  localparam N = `WFM_NUM_TIMERS;

  reg  [31:0]  period [0:N-1];
  reg  [N-1:0] status;
  reg  [N-1:0] mask;
  reg          fault_en;
  reg  [6:0]   pre;
  reg  [N-1:0] flags_q;
  wire         us_tick;
  wire [N-1:0] flags;
  wire [N-1:0] refresh;
  wire [N-1:0] active;
  wire [N-1:0] rise;
  wire [3:0]   pidx;
  wire         pwr;
  wire         st_clr;
  wire         fault_clr;
  wire         wr_mask;
  wire         wr_ctrl;
  reg  [31:0]  next_rdata;

  // each producer pulse restarts its own monitor
  assign refresh[`WFM_T_CELL]     = cell_update_i;
  assign refresh[`WFM_T_THERM]    = therm_update_i;
  assign refresh[`WFM_T_MODSTAT]  = module_status_update_i;
  assign refresh[`WFM_T_OPENWIRE] = open_wire_run_i;           // [RULE9]
  assign refresh[`WFM_T_POWER]    = stack_power_update_i;      // [RULE10]
  assign refresh[`WFM_T_LINKPWR]  = link_power_check_i;        // [RULE11]
  assign refresh[`WFM_T_CTRLCFG]  = controller_config_check_i; // [RULE12]
  assign refresh[`WFM_T_PWRCFG]   = power_side_config_check_i; // [RULE12]
  assign refresh[`WFM_T_RAMGUARD] = ram_selftest_service_i;    // [RULE13]
  assign refresh[`WFM_T_ROMGUARD] = rom_selftest_service_i;    // [RULE13]
  // only installed cells, thermistors and modules are supervised; the rest always run
  assign active[`WFM_T_CELL]    = cells_installed_i;   // [RULE6]
  assign active[`WFM_T_THERM]   = therms_installed_i;  // [RULE7]
  assign active[`WFM_T_MODSTAT] = modules_installed_i; // [RULE8]
  assign active[9:3]            = 7'h7F;

  // microsecond prescaler
  assign us_tick = (pre == `WFM_US_LAST); // [RULE15]
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pre <= 7'h00;
    end else if (us_tick) begin
      pre <= 7'h00;
    end else begin
      pre <= pre + 7'h01;
    end
  end

  // freshness monitors
  // cell data age; held clear while no cells are fitted
  wfm_timer u_cell_tmr (
    .clk_i     (clk_i),
    .rst_n_i   (rst_n_i),
    .us_tick_i (us_tick),
    .refresh_i (refresh[`WFM_T_CELL]),
    .active_i  (active[`WFM_T_CELL]),
    .period_i  (period[`WFM_T_CELL]),
    .flag_o    (flags[`WFM_T_CELL])
  );

  // thermistor data age; the period must cover eight link scans
  wfm_timer u_therm_tmr (
    .clk_i     (clk_i),
    .rst_n_i   (rst_n_i),
    .us_tick_i (us_tick),
    .refresh_i (refresh[`WFM_T_THERM]),
    .active_i  (active[`WFM_T_THERM]),
    .period_i  (period[`WFM_T_THERM]),
    .flag_o    (flags[`WFM_T_THERM])
  );

  // interface module status age
  wfm_timer u_modstat_tmr (
    .clk_i     (clk_i),
    .rst_n_i   (rst_n_i),
    .us_tick_i (us_tick),
    .refresh_i (refresh[`WFM_T_MODSTAT]),
    .active_i  (active[`WFM_T_MODSTAT]),
    .period_i  (period[`WFM_T_MODSTAT]),
    .flag_o    (flags[`WFM_T_MODSTAT])
  );

  // open-wire detection runs
  wfm_timer u_openwire_tmr (
    .clk_i     (clk_i),
    .rst_n_i   (rst_n_i),
    .us_tick_i (us_tick),
    .refresh_i (refresh[`WFM_T_OPENWIRE]),
    .active_i  (active[`WFM_T_OPENWIRE]),
    .period_i  (period[`WFM_T_OPENWIRE]),
    .flag_o    (flags[`WFM_T_OPENWIRE])
  );

  // stack voltage and current samples
  wfm_timer u_power_tmr (
    .clk_i     (clk_i),
    .rst_n_i   (rst_n_i),
    .us_tick_i (us_tick),
    .refresh_i (refresh[`WFM_T_POWER]),
    .active_i  (active[`WFM_T_POWER]),
    .period_i  (period[`WFM_T_POWER]),
    .flag_o    (flags[`WFM_T_POWER])
  );

  // link power-error checks
  wfm_timer u_linkpwr_tmr (
    .clk_i     (clk_i),
    .rst_n_i   (rst_n_i),
    .us_tick_i (us_tick),
    .refresh_i (refresh[`WFM_T_LINKPWR]),
    .active_i  (active[`WFM_T_LINKPWR]),
    .period_i  (period[`WFM_T_LINKPWR]),
    .flag_o    (flags[`WFM_T_LINKPWR])
  );

  // controller side configuration checks
  wfm_timer u_ctrlcfg_tmr (
    .clk_i     (clk_i),
    .rst_n_i   (rst_n_i),
    .us_tick_i (us_tick),
    .refresh_i (refresh[`WFM_T_CTRLCFG]),
    .active_i  (active[`WFM_T_CTRLCFG]),
    .period_i  (period[`WFM_T_CTRLCFG]),
    .flag_o    (flags[`WFM_T_CTRLCFG])
  );

  // power side configuration checks
  wfm_timer u_pwrcfg_tmr (
    .clk_i     (clk_i),
    .rst_n_i   (rst_n_i),
    .us_tick_i (us_tick),
    .refresh_i (refresh[`WFM_T_PWRCFG]),
    .active_i  (active[`WFM_T_PWRCFG]),
    .period_i  (period[`WFM_T_PWRCFG]),
    .flag_o    (flags[`WFM_T_PWRCFG])
  );

  // watchdogs: only these can trip the fault
  // memory self-test service
  wfm_timer u_ramguard_tmr (
    .clk_i     (clk_i),
    .rst_n_i   (rst_n_i),
    .us_tick_i (us_tick),
    .refresh_i (refresh[`WFM_T_RAMGUARD]),
    .active_i  (active[`WFM_T_RAMGUARD]),
    .period_i  (period[`WFM_T_RAMGUARD]),
    .flag_o    (flags[`WFM_T_RAMGUARD])
  );

  // code store self-test service
  wfm_timer u_romguard_tmr (
    .clk_i     (clk_i),
    .rst_n_i   (rst_n_i),
    .us_tick_i (us_tick),
    .refresh_i (refresh[`WFM_T_ROMGUARD]),
    .active_i  (active[`WFM_T_ROMGUARD]),
    .period_i  (period[`WFM_T_ROMGUARD]),
    .flag_o    (flags[`WFM_T_ROMGUARD])
  );

  assign stale_o   = flags[7:0];
  assign expired_o = flags[9:8];
  assign rise      = flags & ~flags_q;
  assign pidx      = addr_i[5:2];
  assign pwr       = wr_i && (addr_i[7:6] == 2'b00) && (pidx < 4'd10);
  assign st_clr    = wr_i && (addr_i == `WFM_A_STATUS);
  assign wr_mask   = wr_i && (addr_i == `WFM_A_MASK);
  assign wr_ctrl   = wr_i && (addr_i == `WFM_A_CTRL);
  assign fault_clr = wr_ctrl && wdata_i[`WFM_CTRL_FAULT_CLR];

  // period registers: how long each monitor may go without a refresh
  // a new period takes effect at once against the running count
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      period[`WFM_T_CELL]     <= `WFM_PER_CELL_US;
      period[`WFM_T_THERM]    <= `WFM_PER_THERM_US;
      period[`WFM_T_MODSTAT]  <= `WFM_PER_MODSTAT_US;
      period[`WFM_T_OPENWIRE] <= `WFM_PER_OPENWIRE_US;
      period[`WFM_T_POWER]    <= `WFM_PER_POWER_US;
      period[`WFM_T_LINKPWR]  <= `WFM_PER_LINKPWR_US;
      period[`WFM_T_CTRLCFG]  <= `WFM_PER_CFG_US;
      period[`WFM_T_PWRCFG]   <= `WFM_PER_CFG_US;
      period[`WFM_T_RAMGUARD] <= `WFM_PER_SELFTEST_US;
      period[`WFM_T_ROMGUARD] <= `WFM_PER_SELFTEST_US;
    end else if (pwr) begin
      period[pidx] <= wdata_i; // [RULE15]
    end
  end

  // interrupt mask
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mask <= 10'h000;
    end else if (wr_mask) begin
      mask <= wdata_i[N-1:0];
    end
  end

  // fault enable, set out of reset so an expiry trips without setup
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fault_en <= 1'b1;
    end else if (wr_ctrl) begin
      fault_en <= wdata_i[`WFM_CTRL_FAULT_EN];
    end
  end

  // edge detector starts at the flags' idle level, so no false event follows reset
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flags_q <= 10'h000;
    end else begin
      flags_q <= flags;
    end
  end

  // new events win over a write-one-to-clear in the same cycle
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      status <= 10'h000;
    end else begin
      status <= (status & ~(st_clr ? wdata_i[N-1:0] : 10'h000)) | rise;
    end
  end

  // fault latches until cleared; an expiry in the clear cycle still trips
  // a clear while a watchdog is still expired and fault_en is set has no effect
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fault_o <= 1'b0;
    end else if (fault_en && |flags[9:8]) begin
      fault_o <= 1'b1; // [RULE3]
    end else if (fault_clr) begin
      fault_o <= 1'b0;
    end
  end

  assign contactor_open_o = fault_o; // [RULE3]
  assign irq_o            = |(status & mask);

  // read mux; unmapped addresses return zero
  always @* begin
    next_rdata = 32'h0000_0000;
    if (rd_i) begin
      case (addr_i)
        8'h00:         next_rdata = period[0];
        8'h04:         next_rdata = period[1];
        8'h08:         next_rdata = period[2];
        8'h0C:         next_rdata = period[3];
        8'h10:         next_rdata = period[4];
        8'h14:         next_rdata = period[5];
        8'h18:         next_rdata = period[6];
        8'h1C:         next_rdata = period[7];
        8'h20:         next_rdata = period[8];
        8'h24:         next_rdata = period[9];
        `WFM_A_FLAGS:  next_rdata = {22'h0, flags};
        `WFM_A_STATUS: next_rdata = {22'h0, status};
        `WFM_A_MASK:   next_rdata = {22'h0, mask};
        `WFM_A_CTRL:   next_rdata = {30'h0, fault_en, fault_o};
        default:       next_rdata = 32'h0000_0000;
      endcase
    end
  end

  // zero outside the read slot, so an old word never lingers on the bus
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= 32'h0000_0000;
    end else begin
      rdata_o <= next_rdata;
    end
  end
endmodule

`default_nettype wire

// file: dv/wfm_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module wfm_asserts (
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  input wire logic        rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic        cell_update_i,
  input wire logic        cells_installed_i,
  input wire logic        ram_selftest_service_i,
  input wire logic        rom_selftest_service_i,
  input wire logic [7:0]  stale_o,
  input wire logic [1:0]  expired_o,
  input wire logic        fault_o,
  input wire logic        contactor_open_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  a_contact_fault: assert property (contactor_open_o == fault_o)
    else $error("contactor does not follow fault");
  a_cell_refresh: assert property (cell_update_i |=> !stale_o[0])
    else $error("cell refresh left stale set");
  a_ram_service: assert property (ram_selftest_service_i |=> !expired_o[0])
    else $error("ram service left expired set");
  a_rom_service: assert property (rom_selftest_service_i |=> !expired_o[1])
    else $error("rom service left expired set");
  a_cell_uninst: assert property (!cells_installed_i [*2] |-> !stale_o[0])
    else $error("uninstalled cells reported stale");
  a_expiry_trip: assert property ($rose(expired_o[0]) |=> fault_o)
    else $error("expiry did not trip fault");
  a_expired_sticky: assert property (expired_o[1] && !rom_selftest_service_i |=> expired_o[1])
    else $error("expired dropped without service");
  a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
    else $error("read data outside read slot");
endmodule
bind wfm_watchdog_freshness_monitor wfm_asserts wfm_asserts_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .rd_i(rd_i), .rdata_o(rdata_o), .cell_update_i(cell_update_i), .cells_installed_i(cells_installed_i),
  .ram_selftest_service_i(ram_selftest_service_i), .rom_selftest_service_i(rom_selftest_service_i),
  .stale_o(stale_o), .expired_o(expired_o), .fault_o(fault_o), .contactor_open_o(contactor_open_o));
`default_nettype wire

// file: dv/wfm_producer.sv
`timescale 1ns/1ps
`default_nettype none
module wfm_producer (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic [9:0] en_i,
  output var  logic [9:0] upd_o
);
  logic [6:0] gap;
  // one refresh every 100 cycles, well inside a 2 us period
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gap   <= 7'h0;
      upd_o <= 10'h0;
    end else begin
      gap   <= (gap == 7'h63) ? 7'h0 : gap + 7'h1;
      upd_o <= (gap == 7'h0) ? en_i : 10'h0;
    end
  end
endmodule
`default_nettype wire

// file: dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "wfm_consts.vh"
module tb;
  logic        clk_i, rst_n_i, wr_s, rd_s, ci, fault, cont, irq;
  logic [7:0]  addr, stale;
  logic [31:0] wdata, rdata;
  logic [9:0]  en, upd;
  logic [1:0]  expd;
  logic [13:0] rows [10];
  int          mismatches, check_count, i;
  wfm_watchdog_freshness_monitor wfm_watchdog_freshness_monitor_inst (.clk_i(clk_i),
    .rst_n_i(rst_n_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr_s), .rd_i(rd_s), .rdata_o(rdata),
    .cell_update_i(upd[0]), .therm_update_i(upd[1]), .module_status_update_i(upd[2]),
    .open_wire_run_i(upd[3]), .stack_power_update_i(upd[4]), .link_power_check_i(upd[5]),
    .controller_config_check_i(upd[6]), .power_side_config_check_i(upd[7]),
    .ram_selftest_service_i(upd[8]), .rom_selftest_service_i(upd[9]), .cells_installed_i(ci),
    .therms_installed_i(1'b1), .modules_installed_i(1'b1), .stale_o(stale), .expired_o(expd),
    .fault_o(fault), .contactor_open_o(cont), .irq_o(irq));
  wfm_producer wfm_producer_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .en_i(en), .upd_o(upd));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk_i);
    wr_s <= 1'b0;
    @(posedge clk_i);
  endtask
  task rc(input logic [7:0] a, input logic [31:0] e);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk_i);
    rd_s <= 1'b0;
    @(negedge clk_i);
    chk(rdata, e);
    @(posedge clk_i);
  endtask
  task finish_test();
    $display("checks=%0d mismatches=%0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  initial begin
    repeat (40000) @(posedge clk_i);
    mismatches++;
    finish_test();
  end
  initial begin
    {rst_n_i, wr_s, rd_s, ci, addr, wdata, en} = {4'h1, 8'h0, 32'h0, 10'h3FF};
    rst_n_i = 1'b0;
    rows = '{14'h0001, 14'h0402, 14'h0804, 14'h0C08, 14'h1010, 14'h1420, 14'h1840, 14'h1C80,
             14'h2100, 14'h2600};
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(negedge clk_i);
    chk({fault, irq, expd, stale}, 32'h0);
    @(posedge clk_i);
    rc(`WFM_A_PERIOD0, `WFM_PER_CELL_US);
    rc(8'h0C, `WFM_PER_OPENWIRE_US);
    rc(8'h20, `WFM_PER_SELFTEST_US);
    rc(`WFM_A_CTRL, {24'h0, `WFM_CTRL_RST});
    rc(8'h80, 32'h0);
    for (i = 0; i < 10; i++) wr(8'(4 * i), 32'h2);
    rc(8'h24, 32'h2);
    for (i = 0; i < 10; i++) begin
      en <= ~(10'h1 << rows[i][13:10]);
      repeat (700) @(posedge clk_i);
      rc(`WFM_A_FLAGS, {22'h0, rows[i][9:0]});
      chk({expd, stale, fault, cont}, {rows[i][9:0], {2{rows[i][13]}}});
      wr(`WFM_A_CTRL, 32'h3);
      @(negedge clk_i);
      chk(fault, rows[i][13]);
      en <= 10'h3FF;
      repeat (150) @(posedge clk_i);
      wr(`WFM_A_CTRL, 32'h3);
      rc(`WFM_A_FLAGS, 32'h0);
      chk({fault, cont}, 32'h0);
    end
    wr(`WFM_A_STATUS, 32'h3FF);
    en <= 10'h3FE;
    repeat (700) @(posedge clk_i);
    chk(irq, 32'h0);
    wr(`WFM_A_MASK, 32'h1);
    chk(irq, 32'h1);
    wr(`WFM_A_STATUS, 32'h1);
    chk(irq, 32'h0);
    ci <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk(stale[0], 32'h0);
    finish_test();
  end
endmodule
`default_nettype wire
